// *** rtl/led_loader_pkg.sv ***
/*
 Shared constants and carrier types for the serial dot-matrix loader.
 Assumes a 25 MHz system clock; all pin timing is resolved by oversampling.
*/
`default_nettype none
package led_loader_pkg;
   localparam int DOT_BITS      = 160;
   localparam int COLS          = 20;
   localparam int ROWS          = 8;
   localparam int CTRL_BITS     = 8;
   localparam int CTRL_SEL_BIT  = 7;
   localparam int FIFO_DEPTH    = 32;
   localparam int REFRESH_CYCLES = 512;
   localparam int ROW_CYCLES    = REFRESH_CYCLES / ROWS;
   localparam int ROW_ON_CYCLES = 60;
   localparam int PRESCALE_DIV  = 8;
   localparam int CLK_PERIOD_NS = 40;
   // Internal display oscillator period (125 kHz)
   localparam int INT_OSC_PERIOD_NS = 8000;
   localparam logic [7:0] INT_OSC_HALF_CYCLES =
      8'(INT_OSC_PERIOD_NS / (2 * CLK_PERIOD_NS));
   localparam logic [6:0] CTRL0_RESET = 7'h00;
   localparam logic [6:0] CTRL1_RESET = 7'h00;
   // Positions in the synchronised pin vector
   localparam int PIN_RS    = 0;
   localparam int PIN_CE    = 1;
   localparam int PIN_SCK   = 2;
   localparam int PIN_DIN   = 3;
   localparam int PIN_BLANK = 4;
   localparam int PIN_OSC   = 5;
   localparam int PIN_SEL   = 6;
   localparam int PIN_COUNT = 7;
   localparam logic [6:0] PIN_RESET = 7'h02;

   typedef struct packed {
      logic       awake;
      logic [1:0] peak;
      logic [3:0] pwm;
   } bright_word_type;

   typedef struct packed {
      logic [4:0] must_zero;
      logic       prescale;
      logic       simul;
   } chain_word_type;

   typedef struct packed {
      logic ctrl_sel;
      logic data;
   } shift_item_type;
endpackage : led_loader_pkg
`default_nettype wire

// *** rtl/led_matrix_loader.sv ***
/*
 Serial load front end and refresh core of a 5x7 dot-matrix LED driver,
 plus the bit FIFO between the pin sampler and the shift registers.
 Assumes the serial pins are asynchronous to CLK and toggle far slower.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Enabled chip shifts data on shift clock rise
// - Dot bit one lights LED, zero darkens
// - Disable plus low clock copies dots to latch
// - Old pattern displayed while new one shifts
// - Select sampled on enable fall, clock not rising
// - Top control bit picks word; other kept
// - Disable plus low clock loads chosen word
// - Word 0 holds PWM, peak current, sleep
// - Sleep stops oscillator and all pixel drivers
// - Dots and control words survive sleep
// - Serial mode: output carries control bit seven
// - Simultaneous mode: output follows input on control
// - Word 1 bit one divides external oscillator by 8
// - Refresh spans 512 display clock cycles
// - Prescaler ignored with internal oscillator
// - Twenty columns of eight; row zero dark
// - Chained dot registers form one long shifter
// - Reset clears control words, enters sleep
// - Blank input high darkens every LED
// - Select pin picks internal or external oscillator

module shift_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             cke,
   // Filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              push = cke & in_valid & in_ready;
   wire              pop  = cke & out_valid & out_ready;

   assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end
endmodule : shift_fifo

module led_matrix_loader
   import led_loader_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              CLK,
   input  wire logic              RSTN,
   input  wire logic              CKE,
   // Serial load pins
   input  wire logic              REGISTER_SELECT,
   input  wire logic              CHIP_EN_N,
   input  wire logic              SHIFT_CLK,
   input  wire logic              SER_DIN,
   output logic                   SER_DOUT,
   output logic                   SHIFT_READY,
   // Display control pins
   input  wire logic              BLANK_INPUT,
   input  wire logic              OSC_SELECT,
   input  wire logic              OSC_I,
   output logic                   OSC_O,
   output logic                   OSC_OE,
   // LED drivers and brightness settings
   output logic      [ROWS-1:0]   ROW_DRIVE,
   output logic      [COLS-1:0]   COL_DRIVE,
   output logic      [3:0]        PWM_LEVEL,
   output logic      [1:0]        PEAK_LEVEL,
   output logic                   AWAKE
);
   logic [PIN_COUNT-1:0] s1_q, s2_q, s3_q, flt_q, prev_q;
   logic                 rs_q, latch_pend_q, dout_q, osc_q, osc_oe_q, dots_valid_q;
   logic [CTRL_BITS-1:0] ctrl_sr_q;
   bright_word_type      ctrl0_q;
   chain_word_type       ctrl1_q;
   logic [DOT_BITS-1:0]  dot_sr_q, dot_latch_q;
   logic [7:0]           osc_cnt_q;
   logic [2:0]           pre_cnt_q;
   logic [8:0]           ref_cnt_q;
   logic [ROWS-1:0]      row_q;
   logic [COLS-1:0]      col_q, col_d;
   shift_item_type       in_item, out_item;
   logic                 fifo_in_ready, fifo_out_valid;

   // Pin sampler: three stages, a change counts once stages two and three agree
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s1_q <= PIN_RESET;
         s2_q <= PIN_RESET;
         s3_q <= PIN_RESET;
      end else if (CKE) begin
         s1_q <= {OSC_SELECT, OSC_I, BLANK_INPUT, SER_DIN, SHIFT_CLK, CHIP_EN_N,
                  REGISTER_SELECT};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_filter
      always_ff @(posedge CLK or negedge RSTN) begin
         if (!RSTN) begin
            flt_q[p]  <= PIN_RESET[p];
            prev_q[p] <= PIN_RESET[p];
         end else if (CKE) begin
            if (s2_q[p] == s3_q[p]) flt_q[p] <= s3_q[p];
            prev_q[p] <= flt_q[p];
         end
      end
   end

   wire ce_n     = flt_q[PIN_CE];
   wire sck      = flt_q[PIN_SCK];
   wire sck_rise = sck & ~prev_q[PIN_SCK];
   wire ce_fall  = ~ce_n & prev_q[PIN_CE];
   wire ce_rise  = ce_n & ~prev_q[PIN_CE];
   wire osc_rise = flt_q[PIN_OSC] & ~prev_q[PIN_OSC];
   wire int_sel  = flt_q[PIN_SEL];
   wire blank    = flt_q[PIN_BLANK];

   // Only an enabled chip queues bits; disabled edges are dropped
   wire push_req = ~ce_n & sck_rise;
   assign in_item = '{ctrl_sel: rs_q, data: flt_q[PIN_DIN]};

   // Copy waits until every queued bit has reached its shift register
   wire latch_go = CKE & latch_pend_q & ce_n & ~sck & ~fifo_out_valid;
   wire pop      = CKE & fifo_out_valid;

   shift_fifo #(
      .WIDTH (2),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rstn      (RSTN),
      .cke       (CKE),
      .in_valid  (push_req),
      .in_data   (in_item),
      .in_ready  (fifo_in_ready),
      .out_valid (fifo_out_valid),
      .out_data  (out_item),
      .out_ready (~latch_go)
   );
   assign SHIFT_READY = fifo_in_ready;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rs_q         <= 1'b0;
         latch_pend_q <= 1'b0;
         ctrl_sr_q    <= '0;
         ctrl0_q      <= CTRL0_RESET;
         ctrl1_q      <= CTRL1_RESET;
         dots_valid_q <= 1'b0;
      end else if (CKE) begin
         // Dot latch holds no defined pattern until the first copy
         if (latch_go && !rs_q) dots_valid_q <= 1'b1;
         if (ce_fall && !sck_rise) rs_q <= flt_q[PIN_RS];
         if (ce_rise) latch_pend_q <= 1'b1;
         else if (latch_go) latch_pend_q <= 1'b0;
         if (pop && out_item.ctrl_sel) begin
            ctrl_sr_q <= {ctrl_sr_q[CTRL_BITS-2:0], out_item.data};
         end
         if (latch_go && rs_q) begin
            if (ctrl_sr_q[CTRL_SEL_BIT]) ctrl1_q <= ctrl_sr_q[6:0];
            else ctrl0_q <= ctrl_sr_q[6:0];
         end
      end
   end

   // Dot store has no reset; sleep leaves it untouched
   always_ff @(posedge CLK) begin
      if (pop && !out_item.ctrl_sel) begin
         dot_sr_q <= {out_item.data, dot_sr_q[DOT_BITS-1:1]};
      end
      if (latch_go && !rs_q) dot_latch_q <= dot_sr_q;
   end

   // Chain output: dot tail, control bit seven, or pass-through
   wire dout_d = (rs_q && ctrl1_q.simul && !ce_n) ? flt_q[PIN_DIN] :
                 rs_q ? ctrl_sr_q[CTRL_SEL_BIT] :
                 dot_sr_q[0];

   // Display clock: internal divider or external pin, with optional prescale
   wire awake     = ctrl0_q.awake;
   wire int_tick  = awake & (osc_cnt_q == INT_OSC_HALF_CYCLES - 8'h01) & ~osc_q;
   wire ext_tick  = osc_rise & (~ctrl1_q.prescale | (pre_cnt_q == 3'(PRESCALE_DIV - 1)));
   wire disp_tick = int_sel ? int_tick : ext_tick;
   wire [2:0] row = ref_cnt_q[8:6];
   wire [5:0] phase = ref_cnt_q[5:0];
   wire drive_en = awake & ~blank & (phase < 6'(ROW_ON_CYCLES)) & (row != 3'h0);
   wire [ROWS-1:0] row_d = drive_en ? ROWS'(8'h01 << row) : 8'h00;

   for (genvar c = 0; c < COLS; c++) begin : g_col
      assign col_d[c] = drive_en & dot_latch_q[c*ROWS + row];
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         osc_cnt_q <= 8'h00;
         osc_q     <= 1'b0;
         osc_oe_q  <= 1'b0;
         pre_cnt_q <= 3'h0;
         ref_cnt_q <= 9'h000;
         row_q     <= '0;
         col_q     <= '0;
         dout_q    <= 1'b0;
      end else if (CKE) begin
         if (awake) begin
            if (osc_cnt_q == INT_OSC_HALF_CYCLES - 8'h01) begin
               osc_cnt_q <= 8'h00;
               osc_q     <= ~osc_q;
            end else begin
               osc_cnt_q <= osc_cnt_q + 8'h01;
            end
         end
         osc_oe_q <= int_sel;
         if (osc_rise) pre_cnt_q <= pre_cnt_q + 3'h1;
         if (disp_tick && awake) ref_cnt_q <= ref_cnt_q + 9'h001;
         row_q  <= row_d;
         col_q  <= col_d;
         dout_q <= dout_d;
      end
   end

   assign SER_DOUT   = dout_q;
   assign OSC_O      = osc_q;
   assign OSC_OE     = osc_oe_q;
   assign ROW_DRIVE  = row_q;
   assign COL_DRIVE  = col_q;
   assign PWM_LEVEL  = ctrl0_q.pwm;
   assign PEAK_LEVEL = ctrl0_q.peak;
   assign AWAKE      = ctrl0_q.awake;

   // Checks
   sequence s_ready_to_copy;
      CKE && ce_rise ##1 (CKE && ce_n && !sck && !fifo_out_valid);
   endsequence

   sequence s_dot_copy;
      CKE && latch_go && !rs_q;
   endsequence

   a_copy_after_release: assert property (@(posedge CLK) disable iff (!RSTN)
      s_ready_to_copy |-> latch_go)
      else $error("copy did not follow enable release");
   a_dot_latch_load: assert property (@(posedge CLK) disable iff (!RSTN)
      s_dot_copy |=> dot_latch_q == $past(dot_sr_q))
      else $error("dot latch missed the shift contents");
   a_dot_latch_hold: assert property (@(posedge CLK) disable iff (!RSTN)
      dots_valid_q && !(latch_go && !rs_q) |=> $stable(dot_latch_q))
      else $error("dot latch changed outside a copy");
   a_disabled_no_shift: assert property (@(posedge CLK) disable iff (!RSTN)
      CKE && ce_n && !fifo_out_valid |=> !fifo_out_valid ##1 $stable(ctrl_sr_q))
      else $error("control shifter moved while disabled");
   a_word0_select: assert property (@(posedge CLK) disable iff (!RSTN)
      latch_go && rs_q && !ctrl_sr_q[7] |=>
         ctrl0_q == $past(ctrl_sr_q[6:0]) && $stable(ctrl1_q))
      else $error("word 0 load wrong");
   a_word1_select: assert property (@(posedge CLK) disable iff (!RSTN)
      latch_go && rs_q && ctrl_sr_q[7] |=>
         ctrl1_q == $past(ctrl_sr_q[6:0]) && $stable(ctrl0_q))
      else $error("word 1 load wrong");
   a_sleep_dark: assert property (@(posedge CLK) disable iff (!RSTN)
      CKE && !ctrl0_q.awake |=> ROW_DRIVE == '0 && COL_DRIVE == '0)
      else $error("drivers active in sleep");
   a_blank_dark: assert property (@(posedge CLK) disable iff (!RSTN)
      CKE && blank |=> COL_DRIVE == '0)
      else $error("columns lit while blanked");
   a_reset_words: assert property (@(posedge CLK)
      !RSTN |-> ctrl0_q == CTRL0_RESET && ctrl1_q == CTRL1_RESET && !AWAKE)
      else $error("control words not cleared by reset");
   a_serial_dout: assert property (@(posedge CLK) disable iff (!RSTN)
      CKE && rs_q && !ctrl1_q.simul |=> SER_DOUT == $past(ctrl_sr_q[7]))
      else $error("serial output not control bit seven");
   a_simul_dout: assert property (@(posedge CLK) disable iff (!RSTN)
      CKE && rs_q && ctrl1_q.simul && !ce_n |=> SER_DOUT == $past(flt_q[PIN_DIN]))
      else $error("simultaneous output not following input");
   a_row_zero_dark: assert property (@(posedge CLK) disable iff (!RSTN)
      CKE && row == 3'h0 |=> ROW_DRIVE == '0)
      else $error("row zero driven");
endmodule : led_matrix_loader
`default_nettype wire

// *** sim/host_model.sv ***
/*
 Host controller model that drives the serial load pins of the loader.
 Assumes clk is the bench clock; every pin changes on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Bench clock
   input  wire logic clk,
   // Serial pins toward the loader
   output logic      rs,
   output logic      ce_n,
   output logic      sck,
   output logic      din,
   output logic      probe
);
   initial begin
      rs = 1'b0;
      ce_n = 1'b1;
      sck = 1'b0;
      din = 1'b0;
      probe = 1'b0;
   end

   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask : ticks

   // Select first, then enable, then the bits; probe marks a settled bit
   task automatic load(input logic sel, input logic [159:0] v, input int n);
      rs = sel;
      ticks(8);
      ce_n = 1'b0;
      ticks(8);
      for (int k = 0; k < n; k++) begin
         din = sel ? v[n-1-k] : v[k];
         sck = 1'b0;
         ticks(4);
         sck = 1'b1;
         ticks(3);
         probe = 1'b1;
         ticks(1);
         probe = 1'b0;
      end
      sck = 1'b0;
      ticks(4);
      ce_n = 1'b1;
      // Released data line no longer shows the last bit
      din = ~din;
      ticks(12);
   endtask : load

   // Shift clock pulses while the chip is not enabled
   task automatic stray(input int n);
      din = 1'b0;
      repeat (n) begin
         sck = 1'b1;
         ticks(4);
         sck = 1'b0;
         ticks(4);
      end
   endtask : stray
endmodule : host_model
`default_nettype wire

// *** sim/testbench.sv ***
/*
 Self-checking bench for the dot-matrix loader with a host pin model.
 Assumes a fast external display oscillator of one rise per 8 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
   import led_loader_pkg::*;
;
   typedef struct packed {
      logic [7:0] cmd;
      logic [6:0] word0;
      logic       simul;
   } row_type;
   logic clk, rstn, blank, osc_sel, osc_i, rs, ce_n, sck, din, probe;
   logic dout, ready, osc_o, osc_oe, awake, mon_en, simul_now, cke;
   logic [27:0]  frozen;
   logic [7:0]   row;
   logic [19:0]  col;
   logic [3:0]   pwm;
   logic [1:0]   peak;
   logic [159:0] shown, pat_a, pat_b;
   int           errors, cmp_count, osc_gap;
   longint       osc_t, t;
   row_type rows [7] = '{'{8'h7F, 7'h7F, 1'b0}, '{8'h80, 7'h7F, 1'b0},
      '{8'h81, 7'h7F, 1'b1}, '{8'h4D, 7'h4D, 1'b1}, '{8'h80, 7'h4D, 1'b0},
      '{8'h3A, 7'h3A, 1'b0}, '{8'h4F, 7'h4F, 1'b0}};

   host_model u_host_model (.clk(clk), .rs(rs), .ce_n(ce_n), .sck(sck), .din(din),
      .probe(probe));

   led_matrix_loader u_led_matrix_loader (.CLK(clk), .RSTN(rstn), .CKE(cke),
      .REGISTER_SELECT(rs), .CHIP_EN_N(ce_n), .SHIFT_CLK(sck), .SER_DIN(din),
      .SER_DOUT(dout), .SHIFT_READY(ready), .BLANK_INPUT(blank), .OSC_SELECT(osc_sel),
      .OSC_I(osc_i), .OSC_O(osc_o), .OSC_OE(osc_oe), .ROW_DRIVE(row), .COL_DRIVE(col),
      .PWM_LEVEL(pwm), .PEAK_LEVEL(peak), .AWAKE(awake));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   function automatic logic [19:0] exp_col(input logic [7:0] r);
      logic [19:0] c;
      int          ri;
      ri = 0;
      for (int i = 0; i < ROWS; i++) begin
         if (r[i]) ri = i;
      end
      for (int k = 0; k < COLS; k++) begin
         c[k] = shown[k*ROWS+ri];
      end
      return c;
   endfunction : exp_col

   // No lit pixel for n cycles
   task automatic dark(input int n);
      repeat (n) begin
         @(negedge clk);
         check(|row & |col, 1'b0);
      end
   endtask : dark

   // Cycles from the start of row 3 to the start of row 4
   task automatic measure(input int exp);
      int n;
      // Start from row 2 so a half-passed row 3 is not counted
      n = 0;
      while (row !== 8'h04 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (row !== 8'h08 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (row !== 8'h10 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      check(n > exp - 8 && n < exp + 8, 1'b1);
   endtask : measure

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      osc_i = 1'b0;
      forever begin
         repeat (4) @(negedge clk);
         osc_i = ~osc_i;
      end
   end

   always @(posedge osc_o) begin
      osc_gap = int'($time - osc_t);
      osc_t = $time;
   end

   always @(posedge clk) begin
      if (mon_en && row != 8'h00) check(col, exp_col(row));
      if (rstn) check(row[0], 1'b0);
      if (probe && simul_now) check(dout, din);
   end

   initial begin
      repeat (95000) @(posedge clk);
      errors++;
      tally_and_finish();
   end

   initial begin
      rstn = 1'b0;
      cke = 1'b1;
      blank = 1'b0;
      osc_sel = 1'b0;
      mon_en = 1'b0;
      simul_now = 1'b0;
      errors = 0;
      cmp_count = 0;
      osc_t = 0;
      osc_gap = 0;
      for (int i = 0; i < DOT_BITS; i++) begin
         pat_a[i] = (i % 3 == 0);
         pat_b[i] = (i % 5 == 1);
      end
      repeat (4) @(negedge clk);
      check({awake, peak, pwm, ready}, 8'h01);
      rstn = 1'b1;
      u_host_model.ticks(8);
      u_host_model.load(1'b0, pat_a, DOT_BITS);
      shown = pat_a;
      check(dout, pat_a[0]);
      mon_en = 1'b1;
      foreach (rows[i]) begin
         u_host_model.load(1'b1, 160'(rows[i].cmd), CTRL_BITS);
         check({awake, peak, pwm}, rows[i].word0);
         if (!rows[i].simul) check(dout, rows[i].cmd[7]);
         simul_now = rows[i].simul;
      end
      u_host_model.ticks(4200);
      fork
         u_host_model.load(1'b0, pat_b, DOT_BITS);
         begin
            wait (ce_n === 1'b0);
            wait (ce_n === 1'b1);
            mon_en = 1'b0;
         end
      join
      shown = pat_b;
      mon_en = 1'b1;
      u_host_model.ticks(4200);
      u_host_model.load(1'b1, 160'h3F, CTRL_BITS);
      dark(600);
      u_host_model.load(1'b1, 160'h4F, CTRL_BITS);
      check(awake, 1'b1);
      // Enable low: a whole control write must leave every state untouched
      cke = 1'b0;
      frozen = {row, col};
      u_host_model.load(1'b1, 160'h40, CTRL_BITS);
      check({row, col}, frozen);
      check({awake, peak, pwm}, 7'h4F);
      cke = 1'b1;
      u_host_model.ticks(4200);
      blank = 1'b1;
      u_host_model.ticks(10);
      dark(600);
      blank = 1'b0;
      measure(512);
      u_host_model.load(1'b1, 160'h82, CTRL_BITS);
      measure(4096);
      u_host_model.load(1'b1, 160'h80, CTRL_BITS);
      check(osc_oe, 1'b0);
      u_host_model.stray(8);
      u_host_model.ticks(10);
      check(dout, 1'b1);
      osc_sel = 1'b1;
      u_host_model.ticks(600);
      check(osc_oe, 1'b1);
      check(osc_gap, 8000);
      u_host_model.load(1'b1, 160'h00, CTRL_BITS);
      u_host_model.ticks(20);
      t = osc_t;
      u_host_model.ticks(600);
      check(osc_t == t, 1'b1);
      u_host_model.load(1'b1, 160'h4F, CTRL_BITS);
      check(awake, 1'b1);
      mon_en = 1'b0;
      rstn = 1'b0;
      u_host_model.ticks(2);
      check({awake, peak, pwm}, 7'h00);
      rstn = 1'b1;
      osc_sel = 1'b0;
      u_host_model.ticks(8);
      u_host_model.load(1'b1, 160'h4F, CTRL_BITS);
      mon_en = 1'b1;
      u_host_model.ticks(4200);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
